// ### hw/sso_top.sv
// status flags, driver enables, interrupt and wishbone registers
// assumes loop status comes from logic on core_clk and board pins
// are asynchronous
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module sso_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // wishbone slave
   input wire sso_pkg::sso_wb_req_t wb_req,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic [31:0] wb_dat_o,
   // board pins
   input wire logic diff_out_a_drive_enable,
   input wire logic diff_out_b_drive_enable,
   input wire logic primary_loop_mode_pin_lo,
   input wire logic primary_loop_mode_pin_hi,
   // loop core status
   input wire sso_pkg::sso_loop_st_t loop_status,
   // loop core mode
   output sso_pkg::sso_mode_t primary_loop_mode,
   // differential driver enables
   output logic diff_out_a_pos_oe_n,
   output logic diff_out_b_pos_oe_n,
   // status pins
   output logic primary_loop_locked_flag,
   output logic primary_loop_holdover_flag,
   // open-drain interrupt pin
   input wire logic interrupt_line_i,
   output logic interrupt_line_o,
   output logic interrupt_line_oe_n
);

   sso_pkg::sso_state_t s_q;
   sso_pkg::sso_state_t s_d;
   sso_pkg::sso_pins_t pins;
   logic [4:0] pins_raw;
   logic in_rst;
   logic lock_now;
   logic [3:0] ev_set;
   logic [3:0] ev_clr;
   logic [1:0] pin_mode_now;
   sso_pkg::sso_reg_t reg_sel;
   logic [31:0] live_word;

   function automatic sso_pkg::sso_reg_t reg_decode(input logic [7:0] adr);
      if (adr == sso_pkg::SSO_ADR_STAT) begin
         return sso_pkg::SSO_REG_STAT;
      end else if (adr == sso_pkg::SSO_ADR_MASK) begin
         return sso_pkg::SSO_REG_MASK;
      end else if (adr == sso_pkg::SSO_ADR_LIVE) begin
         return sso_pkg::SSO_REG_LIVE;
      end else if (adr == sso_pkg::SSO_ADR_MODE) begin
         return sso_pkg::SSO_REG_MODE;
      end else begin
         return sso_pkg::SSO_REG_NONE;
      end
   endfunction : reg_decode

   assign pins_raw = {interrupt_line_i, primary_loop_mode_pin_hi,
      primary_loop_mode_pin_lo, diff_out_b_drive_enable,
      diff_out_a_drive_enable};

   sso_pin_sync #(
      .W(5)
   ) u_pin_sync (
      .core_clk(core_clk),
      .pin_raw(pins_raw),
      .pin_sync(pins)
   );

   // internal reset outlasts the pin by the minimum width
   assign in_rst = rst | (s_q.rst_cnt != sso_pkg::SSO_RST_CYC);
   assign lock_now = loop_status.freq_locked & loop_status.phase_locked;
   assign pin_mode_now = {pins.mode_hi, pins.mode_lo};
   assign reg_sel = reg_decode(wb_req.adr);

   always_comb begin
      live_word = 32'h0;
      live_word[sso_pkg::SSO_LV_LOCK] = s_q.lock;
      live_word[sso_pkg::SSO_LV_HOLD] = s_q.hold;
      live_word[sso_pkg::SSO_LV_A_ON] = s_q.a_on;
      live_word[sso_pkg::SSO_LV_B_ON] = s_q.b_on;
      live_word[sso_pkg::SSO_LV_MODE +: 2] = s_q.mode_out;
      live_word[sso_pkg::SSO_LV_IRQ_PIN] = pins.irq_line;
      live_word[sso_pkg::SSO_LV_MODE_SRC] = s_q.mode_src;
   end

   always_comb begin
      s_d = s_q;
      s_d.ack = 1'b0;
      s_d.err = 1'b0;
      ev_set = 4'h0;
      ev_clr = 4'h0;

      // pins and loop status
      s_d.a_on = pins.a_en;
      s_d.b_on = pins.b_en;
      s_d.lock = lock_now;
      s_d.hold = loop_status.in_holdover;
      s_d.pin_mode = pin_mode_now;

      // every status change is an event
      ev_set[sso_pkg::SSO_EV_LOCK] = lock_now != s_q.lock;
      ev_set[sso_pkg::SSO_EV_HOLD] = loop_status.in_holdover != s_q.hold;
      ev_set[sso_pkg::SSO_EV_DIFF] = (pins.a_en != s_q.a_on) |
         (pins.b_en != s_q.b_on);
      ev_set[sso_pkg::SSO_EV_PINS] = pin_mode_now != s_q.pin_mode;

      // bus: answer one cycle after the request, write at the ack edge
      case (s_q.wb)
         sso_pkg::SSO_WB_IDLE: begin
            if (wb_req.cyc && wb_req.stb) begin
               s_d.wb = sso_pkg::SSO_WB_ACK;
               s_d.ack = reg_sel != sso_pkg::SSO_REG_NONE;
               s_d.err = reg_sel == sso_pkg::SSO_REG_NONE;
               s_d.rdat = 32'h0;
               if (reg_sel == sso_pkg::SSO_REG_STAT) begin
                  s_d.rdat[3:0] = s_q.stat;
               end else if (reg_sel == sso_pkg::SSO_REG_MASK) begin
                  s_d.rdat[3:0] = s_q.mask;
               end else if (reg_sel == sso_pkg::SSO_REG_LIVE) begin
                  s_d.rdat = live_word;
               end else if (reg_sel == sso_pkg::SSO_REG_MODE) begin
                  s_d.rdat[sso_pkg::SSO_MR_VAL +: 2] = s_q.mode_val;
                  s_d.rdat[sso_pkg::SSO_MR_SRC] = s_q.mode_src;
               end
            end
         end
         sso_pkg::SSO_WB_ACK: begin
            s_d.wb = sso_pkg::SSO_WB_IDLE;
            // all fields sit in byte lane 0
            if (s_q.ack && wb_req.we && wb_req.sel[0]) begin
               if (reg_sel == sso_pkg::SSO_REG_STAT) begin
                  ev_clr = wb_req.dat[3:0];
               end else if (reg_sel == sso_pkg::SSO_REG_MASK) begin
                  s_d.mask = wb_req.dat[3:0];
               end else if (reg_sel == sso_pkg::SSO_REG_MODE) begin
                  s_d.mode_val = sso_pkg::sso_mode_t'(
                     wb_req.dat[sso_pkg::SSO_MR_VAL +: 2]);
                  s_d.mode_src = wb_req.dat[sso_pkg::SSO_MR_SRC];
               end
            end
         end
         default: begin
            s_d.wb = sso_pkg::SSO_WB_IDLE;
         end
      endcase

      // set beats clear so no event is lost
      s_d.stat = (s_q.stat & ~ev_clr) | ev_set;

      // after reset the mode follows the pins or the register
      s_d.mode_out = s_d.mode_src ? s_d.mode_val :
         sso_pkg::sso_mode_t'(pin_mode_now);

      s_d.irq = |(s_d.stat & s_d.mask);

      // reset width counter
      if (rst) begin
         s_d.rst_cnt = 5'h0;
      end else if (s_q.rst_cnt != sso_pkg::SSO_RST_CYC) begin
         s_d.rst_cnt = s_q.rst_cnt + 5'h1;
      end

      if (in_rst) begin
         s_d.wb = sso_pkg::SSO_WB_IDLE;
         s_d.ack = 1'b0;
         s_d.err = 1'b0;
         s_d.rdat = 32'h0;
         s_d.lock = 1'b0;
         s_d.hold = 1'b0;
         s_d.stat = 4'h0;
         s_d.mask = sso_pkg::SSO_MASK_RST;
         s_d.irq = 1'b0;
         // pins sampled through reset; last sample is the default
         s_d.mode_src = 1'b0;
         s_d.mode_val = sso_pkg::sso_mode_t'(pin_mode_now);
         s_d.mode_out = sso_pkg::sso_mode_t'(pin_mode_now);
      end
   end

   always_ff @(posedge core_clk) begin
      s_q <= s_d;
   end

   assign wb_ack_o = s_q.ack;
   assign wb_err_o = s_q.err;
   assign wb_dat_o = s_q.rdat;
   assign primary_loop_mode = s_q.mode_out;
   assign diff_out_a_pos_oe_n = ~s_q.a_on;
   assign diff_out_b_pos_oe_n = ~s_q.b_on;
   assign primary_loop_locked_flag = s_q.lock;
   assign primary_loop_holdover_flag = s_q.hold;
   // pull low only, the board pull-up makes the high level
   assign interrupt_line_o = 1'b0;
   assign interrupt_line_oe_n = ~s_q.irq;

   AST_DIFF_A_ON: assert property (@(posedge core_clk) disable iff (rst)
      pins.a_en |=> !diff_out_a_pos_oe_n)
      else $error("driver a not enabled after enable high");

   AST_DIFF_B_INDEP: assert property (@(posedge core_clk) disable iff (rst)
      (pins.b_en && !pins.a_en) |=>
      (!diff_out_b_pos_oe_n && diff_out_a_pos_oe_n))
      else $error("driver b does not follow its own enable");

   AST_DIFF_TRISTATE: assert property (@(posedge core_clk) disable iff (rst)
      $fell(pins.a_en) |=> diff_out_a_pos_oe_n[*2])
      else $error("driver a not tristated after enable low");

   AST_LOCK_CAUSE: assert property (@(posedge core_clk) disable iff (rst)
      primary_loop_locked_flag |->
      $past(loop_status.freq_locked) && $past(loop_status.phase_locked))
      else $error("locked flag without frequency and phase lock");

   AST_HOLD_FOLLOW: assert property (@(posedge core_clk) disable iff (rst)
      (loop_status.in_holdover && !in_rst) |=>
      primary_loop_holdover_flag)
      else $error("holdover flag missing while in holdover");

   AST_LOCK_EVENT_IRQ: assert property (@(posedge core_clk)
      disable iff (rst)
      ($changed(primary_loop_locked_flag) && !$past(in_rst) &&
      s_q.mask[sso_pkg::SSO_EV_LOCK]) |->
      (!interrupt_line_oe_n && s_q.stat[sso_pkg::SSO_EV_LOCK]))
      else $error("lock change did not raise the interrupt");

   AST_IRQ_RELEASED: assert property (@(posedge core_clk) disable iff (rst)
      ((s_q.stat & s_q.mask) == 4'h0) |->
      (interrupt_line_oe_n && !interrupt_line_o))
      else $error("interrupt line pulled with nothing pending");

   AST_MODE_DEFAULT: assert property (@(posedge core_clk) disable iff (rst)
      $fell(in_rst) |->
      (s_q.mode_val == $past(pin_mode_now) && !s_q.mode_src))
      else $error("mode default not taken from pins at reset");

   AST_RESET_WIDTH: assert property (@(posedge core_clk)
      $fell(rst) |-> in_rst[*8] ##1 in_rst[*7] ##1 !in_rst)
      else $error("internal reset width is not fifteen cycles");

   AST_RESET_OUTPUTS: assert property (@(posedge core_clk)
      in_rst |=> (!primary_loop_locked_flag &&
      !primary_loop_holdover_flag && interrupt_line_oe_n))
      else $error("flags or interrupt active during reset");

endmodule : sso_top

// ### hw/sso_pkg.sv
// constants, carriers and state types of the sync status block
// assumes one 50 MHz core clock and a classic wishbone master
//
// What this block does
// - diff output a driver on while enable high
// - diff output b driver on, independent of a
// - enable low tristates the matching driver
// - locked flag high only when freq and phase locked
// - holdover flag high while loop in holdover
// - status change raises interrupt; processor reads status
// - interrupt is active-low open drain, released otherwise
// - mode pins set loop mode in and after reset, until mode register selects its value
// - reset held at least 300 ns
package sso_pkg;

   // timing
   localparam int SSO_CLK_PERIOD_NS = 20;
   localparam int SSO_RST_MIN_NS = 300;
   localparam logic [4:0] SSO_RST_CYC =
      5'((SSO_RST_MIN_NS + SSO_CLK_PERIOD_NS - 1) / SSO_CLK_PERIOD_NS);

   // register map, byte addresses
   localparam logic [7:0] SSO_ADR_STAT = 8'h00;
   localparam logic [7:0] SSO_ADR_MASK = 8'h04;
   localparam logic [7:0] SSO_ADR_LIVE = 8'h08;
   localparam logic [5:0] SSO_IDX_MODE = 6'h1f;
   localparam logic [7:0] SSO_ADR_MODE = {SSO_IDX_MODE, 2'b00};

   // status and mask bit positions
   localparam int SSO_EV_LOCK = 0;
   localparam int SSO_EV_HOLD = 1;
   localparam int SSO_EV_DIFF = 2;
   localparam int SSO_EV_PINS = 3;
   localparam int SSO_EV_W = 4;
   localparam logic [3:0] SSO_MASK_RST = 4'hf;

   // live register bit positions
   localparam int SSO_LV_LOCK = 0;
   localparam int SSO_LV_HOLD = 1;
   localparam int SSO_LV_A_ON = 2;
   localparam int SSO_LV_B_ON = 3;
   localparam int SSO_LV_MODE = 4;
   localparam int SSO_LV_IRQ_PIN = 6;
   localparam int SSO_LV_MODE_SRC = 7;

   // mode register bit positions
   localparam int SSO_MR_VAL = 0;
   localparam int SSO_MR_SRC = 2;

   typedef enum logic [1:0] {
      SSO_MODE_AUTO = 2'h0,
      SSO_MODE_NORMAL = 2'h1,
      SSO_MODE_HOLDOVER = 2'h2,
      SSO_MODE_FREERUN = 2'h3
   } sso_mode_t;

   typedef enum logic [1:0] {
      SSO_WB_IDLE = 2'h1,
      SSO_WB_ACK = 2'h2
   } sso_wb_st_t;

   typedef enum logic [2:0] {
      SSO_REG_NONE, SSO_REG_STAT, SSO_REG_MASK, SSO_REG_LIVE, SSO_REG_MODE
   } sso_reg_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } sso_wb_req_t;

   typedef struct packed {
      logic freq_locked;
      logic phase_locked;
      logic in_holdover;
   } sso_loop_st_t;

   typedef struct packed {
      logic irq_line;
      logic mode_hi;
      logic mode_lo;
      logic b_en;
      logic a_en;
   } sso_pins_t;

   typedef struct packed {
      sso_wb_st_t wb;
      logic ack;
      logic err;
      logic [31:0] rdat;
      logic [4:0] rst_cnt;
      logic a_on;
      logic b_on;
      logic lock;
      logic hold;
      logic [1:0] pin_mode;
      logic [3:0] stat;
      logic [3:0] mask;
      logic mode_src;
      sso_mode_t mode_val;
      sso_mode_t mode_out;
      logic irq;
   } sso_state_t;

endpackage : sso_pkg

// ### hw/sso_pin_sync.sv
// three-stage synchroniser for board-level pins
// assumes pins are asynchronous to core_clk; no reset so that
// pin levels are visible while the device is held in reset
`timescale 1ns/1ps
module sso_pin_sync #(
   parameter int W = 5
) (
   // clock
   input wire logic core_clk,
   // pins and filtered levels
   input wire logic [W-1:0] pin_raw,
   output logic [W-1:0] pin_sync
);

   logic [W-1:0] meta_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge core_clk) begin
            meta_q[i] <= pin_raw[i];
            s2_q[i] <= meta_q[i];
            s3_q[i] <= s2_q[i];
            // a change counts only once two stages agree
            if (s2_q[i] == s3_q[i]) begin
               out_q[i] <= s3_q[i];
            end
         end
      end
   endgenerate

   assign pin_sync = out_q;

endmodule : sso_pin_sync

// ### testbench/sso_board.sv
// board model: pull-up on the open-drain interrupt wire
// assumes the block only pulls the wire low, through its oe_n
`timescale 1ns/1ps
module sso_board (
   // block side of the wire
   input wire logic line_o,
   input wire logic line_oe_n,
   // resolved wire level
   output logic wire_lvl
);
   // pull-up wins whenever the block lets go
   assign wire_lvl = line_oe_n ? 1'b1 : line_o;
endmodule : sso_board

// ### testbench/tb.sv
// self-checking bench for the sync status block
// assumes a classic wishbone host and board pins driven here
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   sso_pkg::sso_wb_req_t wb_req = '0;
   logic ack, err, oe_a_n, oe_b_n, lock_f, hold_f;
   logic irq_o, irq_oe_n, irq_wire, e;
   logic [31:0] rdat, q;
   logic en_a = 1'b1, en_b = 1'b1, pin_lo = 1'b0, pin_hi = 1'b1;
   sso_pkg::sso_loop_st_t loop_st = '0;
   sso_pkg::sso_mode_t mode;
   int n_mismatch = 0, n_checks = 0, cyc_cnt = 0;
   always #10 core_clk = ~core_clk;
   sso_top DUT (.core_clk(core_clk), .rst(rst), .wb_req(wb_req),
      .wb_ack_o(ack), .wb_err_o(err), .wb_dat_o(rdat),
      .diff_out_a_drive_enable(en_a), .diff_out_b_drive_enable(en_b),
      .primary_loop_mode_pin_lo(pin_lo),
      .primary_loop_mode_pin_hi(pin_hi), .loop_status(loop_st),
      .primary_loop_mode(mode), .diff_out_a_pos_oe_n(oe_a_n),
      .diff_out_b_pos_oe_n(oe_b_n), .primary_loop_locked_flag(lock_f),
      .primary_loop_holdover_flag(hold_f),
      .interrupt_line_i(irq_wire), .interrupt_line_o(irq_o),
      .interrupt_line_oe_n(irq_oe_n));
   sso_board board (.line_o(irq_o), .line_oe_n(irq_oe_n),
      .wire_lvl(irq_wire));
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   // hang guard, well above the fewer than two hundred cycles needed
   always @(posedge core_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 3000) begin
         n_mismatch++;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // outputs are read mid-cycle, away from the edge
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle
   // request held until ack or err is sampled high at a rising edge
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge core_clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
      do begin
         @(posedge core_clk);
      end while (ack !== 1'b1 && err !== 1'b1);
      q = rdat;
      e = err;
      wb_req <= '0;
   endtask : wb
   task automatic t_reset();
      chk("lock", lock_f, 0);
      chk("hold", hold_f, 0);
      chk("irq_oe_n", irq_oe_n, 1);
      chk("mode", mode, sso_pkg::SSO_MODE_HOLDOVER);
      wb(0, sso_pkg::SSO_ADR_MASK, 0);
      chk("mask", q[3:0], sso_pkg::SSO_MASK_RST);
      wb(0, sso_pkg::SSO_ADR_MODE, 0);
      chk("mode_reg", q[2:0], 3'h2);
      wb(0, 8'h40, 0);
      chk("unmapped", e, 1);
      @(posedge core_clk);
      pin_hi <= 1'b0;
      pin_lo <= 1'b1;
      settle(8);
      chk("mode_pins", mode, sso_pkg::SSO_MODE_NORMAL);
      wb(1, sso_pkg::SSO_ADR_MODE, 32'h7);
      settle(2);
      chk("mode_reg_sel", mode, sso_pkg::SSO_MODE_FREERUN);
      $display("test reset done");
   endtask : t_reset
   task automatic t_drive();
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         en_a <= i[0];
         en_b <= i[1];
         settle(8);
         chk("oe_a_n", oe_a_n, !i[0]);
         chk("oe_b_n", oe_b_n, !i[1]);
      end
      $display("test drive done");
   endtask : t_drive
   task automatic t_flags();
      @(posedge core_clk);
      loop_st <= '{freq_locked: 1'b1, phase_locked: 1'b0, in_holdover: 1'b0};
      settle(3);
      chk("lock_freq_only", lock_f, 0);
      @(posedge core_clk);
      loop_st <= '{freq_locked: 1'b1, phase_locked: 1'b1, in_holdover: 1'b0};
      settle(3);
      chk("lock", lock_f, 1);
      @(posedge core_clk);
      loop_st <= '{freq_locked: 1'b0, phase_locked: 1'b0, in_holdover: 1'b1};
      settle(3);
      chk("hold", hold_f, 1);
      chk("lock_off", lock_f, 0);
      @(posedge core_clk);
      loop_st <= '0;
      settle(3);
      chk("hold_off", hold_f, 0);
      $display("test flags done");
   endtask : t_flags
   task automatic t_irq();
      wb(1, sso_pkg::SSO_ADR_STAT, 32'hf);
      settle(2);
      chk("irq_clear", irq_oe_n, 1);
      chk("wire_idle", irq_wire, 1);
      wb(1, sso_pkg::SSO_ADR_MASK, 0);
      @(posedge core_clk);
      loop_st <= '{freq_locked: 1'b1, phase_locked: 1'b1, in_holdover: 1'b0};
      settle(3);
      chk("irq_masked", irq_oe_n, 1);
      // host reads status to find the cause
      wb(0, sso_pkg::SSO_ADR_STAT, 0);
      chk("stat_lock", q[sso_pkg::SSO_EV_LOCK], 1);
      wb(1, sso_pkg::SSO_ADR_MASK, 32'h1);
      settle(2);
      chk("irq_on", irq_oe_n, 0);
      chk("wire_low", irq_wire, 0);
      wb(1, sso_pkg::SSO_ADR_STAT, 32'h1);
      settle(2);
      chk("irq_w1c", irq_oe_n, 1);
      // sensed wire needs the synchroniser delay before it reads high
      settle(4);
      wb(0, sso_pkg::SSO_ADR_LIVE, 0);
      chk("live", q, 32'hfd);
      $display("test irq done");
   endtask : t_irq
   initial begin
      // mode pins held steady through reset for the default
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      // internal stretch of the reset runs a further 15 cycles
      settle(20);
      t_reset();
      t_drive();
      t_flags();
      t_irq();
      test_done();
   end
endmodule : tb
